//--- logic/ssm_output_gate.sv
// Output gate of the slave state machine: holds physical outputs at the
// safe value, or at zero in reset, unless the state allows live data.
// Assumes output data and safe value are synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module ssm_output_gate #(
   parameter int OUT_W = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             liveEn,
   input  wire logic [OUT_W-1:0] outData,
   input  wire logic [OUT_W-1:0] safeValue,
   output logic      [OUT_W-1:0] physOut
);
   logic [OUT_W-1:0] physOut_q;
   logic [OUT_W-1:0] physOut_d;

   // Select live data or safe value
   assign physOut_d = liveEn ? outData : safeValue;
   assign physOut   = physOut_q;

   // Registered so outputs never glitch on a state change
   always_ff @(posedge core_clk) begin
      if (rst) begin
         physOut_q <= '0;
      end else begin
         physOut_q <= physOut_d;
      end
   end

   gate_safe_a: assert property (@(posedge core_clk) disable iff (rst)
      !liveEn |=> physOut == $past(safeValue))
      else $error("output not safe while gated");
   gate_live_a: assert property (@(posedge core_clk) disable iff (rst)
      liveEn |=> physOut == $past(outData))
      else $error("output not following data");
endmodule : ssm_output_gate
`default_nettype wire

//--- logic/ssm_params.svh
// Constants for the slave state machine block: state codes, error codes,
// mailbox protocol codes and channel numbers.
// Assumes inclusion by the package, the state machine module and the sim files.
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH
`define SSM_MBX_CH_A        4'h0    // First mailbox channel
`define SSM_MBX_CH_B        4'h1    // Second mailbox channel
`define SSM_PD_CH_FIRST     4'h2    // First process-data channel
`define SSM_REQ_POWERUP     3'h1
`define SSM_REQ_CONFIG      3'h2
`define SSM_REQ_UPDATE      3'h3
`define SSM_REQ_INPUTS      3'h4
`define SSM_REQ_RUNNING     3'h5
`define SSM_ERR_NONE        4'h0
`define SSM_ERR_MBX_SETUP   4'h1
`define SSM_ERR_PD_SETUP    4'h2
`define SSM_ERR_DC_SETUP    4'h3
`define SSM_ERR_BAD_TRANS   4'h4
`define SSM_MBX_PROTO_FILE  4'h4    // File-transfer mailbox protocol code
`endif

//--- logic/ssm_pkg.sv
// Types for the slave state machine block.
// Assumes ssm_params.svh is found on the include path.
`include "ssm_params.svh"
package ssm_pkg;
   // Gray codes along powerup->config->inputs->running
   typedef enum logic [2:0] {
      SSM_POWERUP = 3'b000,
      SSM_CONFIG  = 3'b001,
      SSM_INPUTS  = 3'b011,
      SSM_RUNNING = 3'b010,
      SSM_UPDATE  = 3'b100
   } ssm_state_t;
endpackage : ssm_pkg

//--- logic/ssm_slave_state_machine.sv
// Per-slave communication state machine: state changes on master request,
// configuration checks, traffic gating, input snapshot and output gate.
// Assumes one clock, synchronous reset, and that setup-valid flags are
// computed by the surrounding controller from the channel setup it holds.
`timescale 1ns/100ps
`default_nettype none
`include "ssm_params.svh"
//  Contract
// - After reset the slave sits in power-up and refuses mailbox and process data.
// - Power-up to config is entered only if the mailbox channel setup is valid.
// - In config mailbox traffic is accepted but no process data.
// - Config to inputs-only checks process-data and, if used, clock settings.
// - Inputs are copied to shared memory before entry to inputs-only from config is acknowledged.
// - Inputs-only allows all traffic, refreshes inputs, holds outputs safe while monitoring is on.
// - With monitoring on outputs take the safe value, else they may drive in inputs-only.
// - Running copies output data to physical outputs with all traffic allowed.
// - Firmware update accepts only file-transfer mailbox traffic.
module ssm_slave_state_machine
   import ssm_pkg::*;
#(
   parameter int OUT_W = 8,
   parameter int IN_W  = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             reqValid,
   input  wire logic [2:0]       reqState,
   input  wire logic             mbxSetupOk,
   input  wire logic             pdSetupOk,
   input  wire logic             dcUsed,
   input  wire logic             dcSetupOk,
   input  wire logic             outDataValid,
   input  wire logic             monitorEn,
   input  wire logic             mbxReq,
   input  wire logic [3:0]       mbxProto,
   input  wire logic             pdReq,
   input  wire logic             inputTick,
   input  wire logic [IN_W-1:0]  inputPins,
   input  wire logic [OUT_W-1:0] outData,
   input  wire logic [OUT_W-1:0] safeValue,
   output logic                  reqAck,
   output logic                  reqErr,
   output logic [3:0]            errCode,
   output logic [2:0]            curState,
   output logic                  mbxAccept,
   output logic                  mbxReject,
   output logic                  pdAccept,
   output logic                  pdReject,
   output logic [IN_W-1:0]       inputImage,
   output logic                  inputWrite,
   output logic [OUT_W-1:0]      physOut
);
   ssm_state_t      state_q, state_d;
   logic [3:0]      errCode_q, errCode_d;
   logic            ack_q, ack_d, err_q, err_d;
   logic [IN_W-1:0] image_q;
   logic            snapPend_q;
   logic            inWr_q;

   // Check helper, used by the config to inputs-only transition
   function automatic logic pdChecksPass(input logic pd, input logic used, input logic dc);
      pdChecksPass = pd && (!used || dc);
   endfunction : pdChecksPass

   // Request decode
   wire reqConfig  = reqValid && (reqState == `SSM_REQ_CONFIG);
   wire reqUpdate  = reqValid && (reqState == `SSM_REQ_UPDATE);
   wire reqInputs  = reqValid && (reqState == `SSM_REQ_INPUTS);
   wire reqRunning = reqValid && (reqState == `SSM_REQ_RUNNING);
   wire reqPowerup = reqValid && (reqState == `SSM_REQ_POWERUP);
   wire pdOk       = pdChecksPass(pdSetupOk, dcUsed, dcSetupOk);

   // Traffic gating per state
   wire inPowerup  = (state_q == SSM_POWERUP);
   wire inUpdate   = (state_q == SSM_UPDATE);
   wire fileProto  = (mbxProto == `SSM_MBX_PROTO_FILE);
   wire mbxAllowed = !inPowerup && (!inUpdate || fileProto);
   wire pdAllowed  = (state_q == SSM_INPUTS) || (state_q == SSM_RUNNING);
   assign mbxAccept = mbxReq && mbxAllowed;
   assign mbxReject = mbxReq && !mbxAllowed;
   assign pdAccept  = pdReq && pdAllowed;
   assign pdReject  = pdReq && !pdAllowed;

   // Live outputs only in running, or in inputs-only with monitoring off
   wire liveEn = (state_q == SSM_RUNNING) || ((state_q == SSM_INPUTS) && !monitorEn);

   // Next state; the entry from config into inputs-only waits for the snapshot, so the
   // ack of that move is given a cycle later from snapPend_q
   always_comb begin
      state_d   = state_q;
      errCode_d = errCode_q;
      ack_d     = 1'b0;
      err_d     = 1'b0;
      if (snapPend_q) begin
         state_d = SSM_INPUTS;
         ack_d   = 1'b1;
      end else if (reqPowerup) begin
         state_d   = SSM_POWERUP;
         errCode_d = `SSM_ERR_NONE;
         ack_d     = 1'b1;
      end else if (reqValid) begin
         unique case (state_q)
            SSM_POWERUP: begin
               if (reqConfig && mbxSetupOk) begin
                  state_d = SSM_CONFIG;
                  ack_d   = 1'b1;
               end else if (reqConfig) begin
                  errCode_d = `SSM_ERR_MBX_SETUP;
                  err_d     = 1'b1;
               end else if (reqUpdate) begin
                  state_d = SSM_UPDATE;
                  ack_d   = 1'b1;
               end else begin
                  errCode_d = `SSM_ERR_BAD_TRANS;
                  err_d     = 1'b1;
               end
            end
            SSM_CONFIG: begin
               if (reqInputs && pdOk) begin
                  ack_d = 1'b0; // Ack follows the snapshot
               end else if (reqInputs) begin
                  errCode_d = pdSetupOk ? `SSM_ERR_DC_SETUP : `SSM_ERR_PD_SETUP;
                  err_d     = 1'b1;
               end else if (reqConfig) begin
                  ack_d = 1'b1;
               end else begin
                  errCode_d = `SSM_ERR_BAD_TRANS;
                  err_d     = 1'b1;
               end
            end
            SSM_INPUTS: begin
               if (reqRunning && outDataValid) begin
                  state_d = SSM_RUNNING;
                  ack_d   = 1'b1;
               end else if (reqConfig) begin
                  state_d = SSM_CONFIG;
                  ack_d   = 1'b1;
               end else begin
                  errCode_d = `SSM_ERR_BAD_TRANS;
                  err_d     = 1'b1;
               end
            end
            SSM_RUNNING: begin
               if (reqInputs || reqConfig) begin
                  state_d = reqInputs ? SSM_INPUTS : SSM_CONFIG;
                  ack_d   = 1'b1;
               end else begin
                  errCode_d = `SSM_ERR_BAD_TRANS;
                  err_d     = 1'b1;
               end
            end
            SSM_UPDATE: begin
               errCode_d = `SSM_ERR_BAD_TRANS; // Only power-up leaves update
               err_d     = 1'b1;
            end
            default: begin
               state_d = SSM_POWERUP;
            end
         endcase
      end
   end

   wire startSnap = !snapPend_q && reqInputs && (state_q == SSM_CONFIG) && pdOk;
   wire cycSnap   = inputTick && pdAllowed; // Cyclic refresh in inputs-only and running

   // State and answer registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q   <= SSM_POWERUP;
         errCode_q <= `SSM_ERR_NONE;
         ack_q     <= 1'b0;
         err_q     <= 1'b0;
      end else begin
         state_q   <= state_d;
         errCode_q <= errCode_d;
         ack_q     <= ack_d;
         err_q     <= err_d;
      end
   end

   // Input snapshot into the shared memory image
   always_ff @(posedge core_clk) begin
      if (rst) begin
         image_q    <= '0;
         snapPend_q <= 1'b0;
         inWr_q     <= 1'b0;
      end else begin
         snapPend_q <= startSnap;
         inWr_q     <= startSnap || cycSnap;
         if (startSnap || cycSnap) begin
            image_q <= inputPins;
         end
      end
   end

   assign reqAck     = ack_q;
   assign reqErr     = err_q;
   assign errCode    = errCode_q;
   assign curState   = state_q;
   assign inputImage = image_q;
   assign inputWrite = inWr_q;

   ssm_output_gate #(
      .OUT_W (OUT_W)
   ) u_gate (
      .core_clk  (core_clk),
      .rst       (rst),
      .liveEn    (liveEn),
      .outData   (outData),
      .safeValue (safeValue),
      .physOut   (physOut)
   );

   powerup_gate_a: assert property (@(posedge core_clk) disable iff (rst)
      (curState == SSM_POWERUP) |-> !mbxAccept && !pdAccept)
      else $error("traffic accepted in power-up");
   config_check_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == SSM_POWERUP) && reqConfig && !mbxSetupOk && !snapPend_q
      |=> state_q == SSM_POWERUP && reqErr && errCode == `SSM_ERR_MBX_SETUP)
      else $error("bad mailbox setup not refused");
   config_pd_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == SSM_CONFIG) |-> mbxAllowed && !pdAccept)
      else $error("config state gating wrong");
   inputs_check_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == SSM_CONFIG) && reqInputs && !pdOk && !snapPend_q
      |=> state_q == SSM_CONFIG && reqErr)
      else $error("bad process-data setup not refused");
   snap_before_ack_a: assert property (@(posedge core_clk) disable iff (rst)
      startSnap |=> inputWrite && inputImage == $past(inputPins) ##1
      reqAck && curState == SSM_INPUTS)
      else $error("inputs-only acked without snapshot");
   safe_outputs_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == SSM_INPUTS) && monitorEn |=> physOut == $past(safeValue))
      else $error("outputs not safe in inputs-only");
   update_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_q != SSM_POWERUP) && (state_q != SSM_UPDATE) && !snapPend_q && reqUpdate
      |=> state_q != SSM_UPDATE && reqErr)
      else $error("update entered from wrong state");
   update_mbx_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == SSM_UPDATE) && mbxReq |-> mbxAccept == fileProto && !pdAccept)
      else $error("update state gating wrong");
   run_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == SSM_INPUTS) && reqRunning && !outDataValid && !snapPend_q
      |=> state_q == SSM_INPUTS)
      else $error("running entered without valid data");

   cov_to_run_c:  cover property (@(posedge core_clk) disable iff (rst)
      state_q == SSM_INPUTS ##1 state_q == SSM_RUNNING);
   cov_update_c:  cover property (@(posedge core_clk) disable iff (rst)
      state_q == SSM_UPDATE && mbxAccept);
   cov_err_c:     cover property (@(posedge core_clk) disable iff (rst) reqErr);
   cov_snap_c:    cover property (@(posedge core_clk) disable iff (rst) startSnap);
endmodule : ssm_slave_state_machine
`default_nettype wire

//--- sim/ssm_master_model.sv
// Behavioural bus master: issues one state request at a time and waits for the answer.
// Assumes the slave answers within four cycles of the edge that takes the request.
`timescale 1ns/100ps
`default_nettype none
`include "ssm_params.svh"
module ssm_master_model (
   input  wire logic       core_clk,
   input  wire logic       reqAck,
   input  wire logic       reqErr,
   output var  logic       reqValid,
   output var  logic [2:0] reqState,
   output var  logic       outDataValid
);
   // Idle request lines; output data counts as delivered only when running is asked
   initial begin
      reqValid     = 1'b0;
      reqState     = 3'h0;
      outDataValid = 1'b0;
   end

   logic withData = 1'b1; // Cleared only to provoke a running request without data

   // Lets the bench withhold output data to reach the refusal path
   task automatic set_data(input logic on);
      withData = on;
   endtask : set_data

   // One strobe, then a bounded wait so a lost answer cannot hang the master
   task automatic send(input logic [2:0] st, output logic ack, output logic err);
      ack = 1'b0;
      err = 1'b0;
      @(posedge core_clk);
      // Output data is marked delivered a full cycle before running is asked
      if (st == `SSM_REQ_RUNNING) begin
         outDataValid <= withData;
         @(posedge core_clk);
      end
      reqValid <= 1'b1;
      reqState <= st;
      @(posedge core_clk);
      reqValid <= 1'b0;
      reqState <= ~st;                 // Stale code must not matter once the strobe drops
      repeat (4) begin
         @(negedge core_clk);
         ack |= (reqAck === 1'b1);
         err |= (reqErr === 1'b1);
      end
   endtask : send
endmodule : ssm_master_model
`default_nettype wire

//--- sim/ssm_slave_state_machine_tb_top.sv
// Self-checking bench for the slave state machine, walking every state and the refusals of power-up, config, inputs-only and running.
// Assumes the master model in ssm_master_model.sv and the design package on the path.
`timescale 1ns/100ps
`default_nettype none
`include "ssm_params.svh"
module ssm_slave_state_machine_tb_top
   import ssm_pkg::*;
;
   logic       core_clk, rst, mbxSetupOk, pdSetupOk, dcUsed, dcSetupOk, monitorEn;
   logic       mbxReq, pdReq, inputTick, reqValid, outDataValid, reqAck, reqErr;
   logic       mbxAccept, mbxReject, pdAccept, pdReject, inputWrite;
   logic [2:0] reqState, curState;
   logic [3:0] mbxProto, errCode;
   logic [7:0] inputPins, outData, safeValue, inputImage, physOut;
   int         n_mismatch = 0, n_tests = 0, nWrites = 0, nw;

   ssm_slave_state_machine u_dut (.core_clk(core_clk), .rst(rst), .reqValid(reqValid),
      .reqState(reqState), .mbxSetupOk(mbxSetupOk), .pdSetupOk(pdSetupOk), .dcUsed(dcUsed),
      .dcSetupOk(dcSetupOk), .outDataValid(outDataValid), .monitorEn(monitorEn),
      .mbxReq(mbxReq), .mbxProto(mbxProto), .pdReq(pdReq), .inputTick(inputTick),
      .inputPins(inputPins), .outData(outData), .safeValue(safeValue), .reqAck(reqAck),
      .reqErr(reqErr), .errCode(errCode), .curState(curState), .mbxAccept(mbxAccept),
      .mbxReject(mbxReject), .pdAccept(pdAccept), .pdReject(pdReject),
      .inputImage(inputImage), .inputWrite(inputWrite), .physOut(physOut));
   ssm_master_model u_master (.core_clk(core_clk), .reqAck(reqAck), .reqErr(reqErr),
      .reqValid(reqValid), .reqState(reqState), .outDataValid(outDataValid));

   // 250 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Count snapshot pulses mid-cycle, where they have settled
   always @(negedge core_clk) if (inputWrite === 1'b1) nWrites++;

   // Expected gate outputs {mbxAccept, mbxReject, pdAccept, pdReject}
   function automatic logic [3:0] expTraffic(input logic [3:0] p, input ssm_state_t st);
      logic m, d;
      d = (st == SSM_INPUTS) || (st == SSM_RUNNING);
      m = d || (st == SSM_CONFIG) || (st == SSM_UPDATE && p == `SSM_MBX_PROTO_FILE);
      return {m, !m, d, !d};
   endfunction : expTraffic

   // Live data only when running, or in inputs-only with monitoring off
   function automatic logic [7:0] expOut(input ssm_state_t st);
      return (st == SSM_RUNNING || (st == SSM_INPUTS && !monitorEn)) ? outData : safeValue;
   endfunction : expOut

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   // A request through the master, then answer, state and error code
   task automatic req(input logic [2:0] st, input ssm_state_t s, input logic [1:0] ae,
                      input logic [3:0] code);
      logic a, e;
      u_master.send(st, a, e);
      check(8'({a, e}), 8'(ae));
      check(8'(curState), 8'(s));
      check(8'(errCode), 8'(code));
   endtask : req

   // Traffic gating is combinational, so it is compared in the same cycle
   task automatic traffic(input logic [3:0] p, input ssm_state_t st);
      @(posedge core_clk);
      mbxReq   <= 1'b1;
      pdReq    <= 1'b1;
      mbxProto <= p;
      @(negedge core_clk);
      check(8'({mbxAccept, mbxReject, pdAccept, pdReject}), 8'(expTraffic(p, st)));
   endtask : traffic

   // Fresh data and safe value; physOut follows one cycle behind its source
   task automatic outs(input ssm_state_t st);
      @(posedge core_clk) begin
         outData   <= 8'($urandom);
         safeValue <= 8'($urandom);
      end
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      check(physOut, expOut(st));
   endtask : outs

   task automatic give_verdict();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   // Main sequence: refusals first at each step up to running, then the good transition
   initial begin
      {rst, mbxSetupOk, pdSetupOk, dcUsed, dcSetupOk, monitorEn} = 6'h21;
      {mbxReq, pdReq, inputTick, mbxProto} = 7'h00;
      {inputPins, outData, safeValue} = 24'h00_0000;
      void'($urandom(32'h0fc6_77b5));
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      check(8'(curState), 8'(SSM_POWERUP));
      traffic(4'h4, SSM_POWERUP);
      req(`SSM_REQ_CONFIG, SSM_POWERUP, 2'b01, `SSM_ERR_MBX_SETUP);
      @(posedge core_clk) mbxSetupOk <= 1'b1;
      req(`SSM_REQ_CONFIG, SSM_CONFIG, 2'b10, `SSM_ERR_MBX_SETUP);
      for (int i = 0; i < 4; i++) traffic(4'($urandom), SSM_CONFIG);
      req(`SSM_REQ_UPDATE, SSM_CONFIG, 2'b01, `SSM_ERR_BAD_TRANS);
      @(posedge core_clk) begin
         inputPins <= 8'($urandom);
         dcUsed    <= 1'b1;
      end
      req(`SSM_REQ_INPUTS, SSM_CONFIG, 2'b01, `SSM_ERR_PD_SETUP);
      @(posedge core_clk) pdSetupOk <= 1'b1;
      req(`SSM_REQ_INPUTS, SSM_CONFIG, 2'b01, `SSM_ERR_DC_SETUP);
      @(posedge core_clk) dcSetupOk <= 1'b1;
      nw = nWrites;
      req(`SSM_REQ_INPUTS, SSM_INPUTS, 2'b10, `SSM_ERR_DC_SETUP);
      check(8'(nWrites - nw), 8'h01);
      check(inputImage, inputPins);
      for (int i = 0; i < 4; i++) traffic(4'($urandom), SSM_INPUTS);
      @(posedge core_clk) begin
         inputPins <= 8'($urandom);
         inputTick <= 1'b1;
      end
      @(posedge core_clk) inputTick <= 1'b0;
      @(negedge core_clk);
      check(inputImage, inputPins);
      outs(SSM_INPUTS);
      @(posedge core_clk) monitorEn <= 1'b0;
      outs(SSM_INPUTS);
      u_master.set_data(1'b0);
      req(`SSM_REQ_RUNNING, SSM_INPUTS, 2'b01, `SSM_ERR_BAD_TRANS);
      u_master.set_data(1'b1);
      req(`SSM_REQ_RUNNING, SSM_RUNNING, 2'b10, `SSM_ERR_BAD_TRANS);
      for (int i = 0; i < 4; i++) traffic(4'($urandom), SSM_RUNNING);
      outs(SSM_RUNNING);
      req(`SSM_REQ_UPDATE, SSM_RUNNING, 2'b01, `SSM_ERR_BAD_TRANS);
      req(`SSM_REQ_POWERUP, SSM_POWERUP, 2'b10, `SSM_ERR_NONE);
      req(`SSM_REQ_UPDATE, SSM_UPDATE, 2'b10, `SSM_ERR_NONE);
      for (int p = 0; p < 16; p++) traffic(4'(p), SSM_UPDATE);
      outs(SSM_UPDATE);
      // Clock settings unused: process-data check alone decides the move
      req(`SSM_REQ_POWERUP, SSM_POWERUP, 2'b10, `SSM_ERR_NONE);
      @(posedge core_clk) {dcUsed, dcSetupOk} <= 2'b00;
      req(`SSM_REQ_CONFIG, SSM_CONFIG, 2'b10, `SSM_ERR_NONE);
      req(`SSM_REQ_INPUTS, SSM_INPUTS, 2'b10, `SSM_ERR_NONE);
      give_verdict();
   end

   // Watchdog: the sequence needs under two hundred cycles, this allows five thousand
   initial begin
      #20000;
      n_mismatch++;
      give_verdict();
   end
endmodule : ssm_slave_state_machine_tb_top
`default_nettype wire
